// >>> design/nbdj_params.svh
`ifndef NBDJ_PARAMS_SVH
`define NBDJ_PARAMS_SVH

`define DATAPATH_CONTROL_ADDR  15'h0116
`define DATAPATH_CONTROL_RESET 8'h00
`define MIXER_BYPASS_BIT       1
`define BURST_PATH_BIT         2
`define COMB_BYPASS_BIT        4
`define SAMPLE_W               16
`define FIFO_DEPTH             32
`define FIFO_RESERVE           8
`define STAGE_COUNT            4

`endif

// >>> design/nbdj_pkg.sv
package nbdj_pkg;

    typedef struct packed {
        logic signed [15:0] q;
        logic signed [15:0] i;
    } iq_t;

    typedef struct packed {
        logic [2:0] upper_bits;
        logic       comb_bypass_select;
        logic       spare_bit;
        logic       burst_path_select;
        logic       mixer_bypass_select;
        logic       low_bit;
    } datapath_control_t;

    typedef struct packed {
        logic       en;
        logic [2:0] factor;
    } slot_cfg_t;

    typedef slot_cfg_t [3:0] chain_cfg_t;

endpackage

// >>> design/sample_fifo.sv
`timescale 1ns/1ps
module sample_fifo #(
    parameter int WIDTH   = 32,
    parameter int DEPTH   = 32,
    parameter int RESERVE = 8
) (
    input  logic             clk,
    input  logic             rst_n,
    input  logic             in_valid,
    output logic             in_ready,
    output logic             in_room,
    input  logic [WIDTH-1:0] in_data,
    output logic             out_valid,
    input  logic             out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    localparam logic [AW:0] DEPTH_C = (AW+1)'(DEPTH);
    localparam logic [AW:0] ROOM_C  = (AW+1)'(DEPTH - RESERVE);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_ptr_q;
    logic [AW-1:0]    rd_ptr_q;
    logic [AW:0]      count_q;
    logic             push;
    logic             pop;

    ////////////////////////////////////////////////////////////////////////////
    assign in_ready = count_q < DEPTH_C;
    // Room leaves space for samples already inside the filter pipeline
    assign in_room  = count_q < ROOM_C;
    assign push     = in_valid & in_ready;
    assign pop      = (count_q != '0) & (~out_valid | out_ready);

    always_ff @(posedge clk) begin
        if (push) begin
            mem[wr_ptr_q] <= in_data;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_ptr_q <= '0;
            rd_ptr_q <= '0;
            count_q  <= '0;
        end else begin
            if (push) begin
                wr_ptr_q <= wr_ptr_q + 1'b1;
            end
            if (pop) begin
                rd_ptr_q <= rd_ptr_q + 1'b1;
            end
            count_q <= count_q + (AW+1)'(push) - (AW+1)'(pop);
        end
    end

    // Registered head so the drain side sees flop outputs
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            out_valid <= 1'b0;
            out_data  <= '0;
        end else if (pop) begin
            out_valid <= 1'b1;
            out_data  <= mem[rd_ptr_q];
        end else if (out_ready) begin
            out_valid <= 1'b0;
        end
    end
endmodule

// >>> design/nonburst_decimate_j_chain.sv
// How it works
// - Source is raw converter or comb output
// - Mixer bypass bit skips frequency translation
// - Burst path bit decides decimate-by-J presence
// - Raw converter samples get decimation only
// - Ratios 1..60 supported with only mixer bypassed, 1 is pass-through; mixing allows 1,4,8,16, raw 8,12,16,20,24,40,60
// - Ratios 4,8,16 use half-band stages
// - Ratios 10,20,40 use fifth-band stage
// - Ratios 12,24,30,60 use third-band stage
// - Every setting keeps same relative passband
// - Input rate is converter rate over comb ratio
// - Decimators follow the frequency translation
// - Comb bypass sends raw samples, forces mixer out
// - Comb gives one 16-bit sample per period
// - Burst path bit bypasses decimate-by-J entirely
// - Output is a stream of 16-bit I/Q sample pairs
`timescale 1ns/1ps
`include "nbdj_params.svh"
module nonburst_decimate_j_chain (
    input  logic           CLK_SYS,
    input  logic           RSTN,
    input  logic           CFG_WE,
    input  logic [14:0]    CFG_ADDR,
    input  logic [7:0]     CFG_WDATA,
    output logic [7:0]     CFG_RDATA,
    input  logic           ADC_VALID,
    input  logic [15:0]    ADC_DATA,
    input  logic           COMB_VALID,
    input  logic [15:0]    COMB_DATA,
    input  logic [15:0]    OSC_COS,
    input  logic [15:0]    OSC_SIN,
    input  logic [5:0]     J_RATIO,
    output logic           SAMPLE_READY,
    output logic           RATIO_ERR,
    output logic           OUT_VALID,
    input  logic           OUT_READY,
    output nbdj_pkg::iq_t  OUT_DATA
);
    import nbdj_pkg::*;

    function automatic logic signed [15:0] mul_q15(input logic signed [15:0] a, input logic signed [15:0] b);
        logic signed [31:0] p;
        p = a * b;
        return p[30:15];
    endfunction

    // Boxcar average stands in for each stage's coefficient set
    // Thirds and fifths rounded up so a steady positive level passes at unity gain
    function automatic logic signed [15:0] stage_avg(input logic signed [19:0] s, input logic [2:0] f);
        logic signed [36:0] p;
        p = '0;
        case (f)
            3'h2:    p = 37'(s) * 37'sh08000;
            3'h3:    p = 37'(s) * 37'sh05556;
            3'h5:    p = 37'(s) * 37'sh03334;
            default: p = 37'(s) <<< 16;
        endcase
        return p[31:16];
    endfunction

    function automatic chain_cfg_t cfg_for(input logic [5:0] j);
        chain_cfg_t c;
        c = '0;
        case (j)
            6'h04:   c = {4'h0, 4'h0, 4'hA, 4'hA};
            6'h08:   c = {4'h0, 4'hA, 4'hA, 4'hA};
            6'h10:   c = {4'hA, 4'hA, 4'hA, 4'hA};
            6'h0A:   c = {4'h0, 4'h0, 4'hD, 4'hA};
            6'h14:   c = {4'h0, 4'hA, 4'hD, 4'hA};
            6'h28:   c = {4'hA, 4'hA, 4'hD, 4'hA};
            6'h0C:   c = {4'h0, 4'hB, 4'hA, 4'hA};
            6'h18:   c = {4'hA, 4'hB, 4'hA, 4'hA};
            6'h1E:   c = {4'h0, 4'hB, 4'hD, 4'hA};
            6'h3C:   c = {4'hA, 4'hB, 4'hD, 4'hA};
            default: c = '0;
        endcase
        return c;
    endfunction

    function automatic logic ratio_ok(input logic [5:0] j, input logic comb_byp, input logic mix_byp);
        logic any_j;
        any_j = j inside {6'h01, 6'h04, 6'h08, 6'h0A, 6'h0C, 6'h10, 6'h14, 6'h18, 6'h1E, 6'h28, 6'h3C};
        if (comb_byp) begin
            return j inside {6'h08, 6'h0C, 6'h10, 6'h14, 6'h18, 6'h28, 6'h3C};
        end else if (mix_byp) begin
            return any_j;
        end
        return j inside {6'h01, 6'h04, 6'h08, 6'h10};
    endfunction

    logic                     rst_meta_q;
    logic                     rst_n;
    datapath_control_t        ctrl_q;
    logic                     mix_on;
    logic                     cfg_ok;
    logic                     src_valid;
    logic signed [15:0]       src_data;
    logic                     accept;
    chain_cfg_t               cfg;
    iq_t                      mix_q;
    logic                     mix_v_q;
    iq_t                      stg_in  [4];
    logic                     stg_v   [4];
    iq_t                      slot_out_q [4];
    logic                     slot_v_q   [4];
    logic signed [19:0]       acc_i_q    [4];
    logic signed [19:0]       acc_q_q    [4];
    logic [2:0]               slot_cnt_q [4];
    logic                     fifo_wv;
    iq_t                      fifo_wd;
    logic                     fifo_in_ready;
    logic                     fifo_in_room;

    ////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge CLK_SYS or negedge RSTN) begin
        if (!RSTN) begin
            rst_meta_q <= 1'b0;
            rst_n      <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_n      <= rst_meta_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge CLK_SYS or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_q <= `DATAPATH_CONTROL_RESET;
        end else if (CFG_WE && CFG_ADDR == `DATAPATH_CONTROL_ADDR) begin
            ctrl_q <= CFG_WDATA;
        end
    end

    always_ff @(posedge CLK_SYS or negedge rst_n) begin
        if (!rst_n) begin
            CFG_RDATA    <= 8'h00;
            RATIO_ERR    <= 1'b0;
            SAMPLE_READY <= 1'b0;
        end else begin
            CFG_RDATA    <= (CFG_ADDR == `DATAPATH_CONTROL_ADDR) ? 8'(ctrl_q) : 8'h00;
            RATIO_ERR    <= ~cfg_ok;
            SAMPLE_READY <= fifo_in_room;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Comb output already arrives at the converter rate over the comb ratio
    assign src_valid = ctrl_q.comb_bypass_select ? ADC_VALID : COMB_VALID;
    assign src_data  = ctrl_q.comb_bypass_select ? ADC_DATA : COMB_DATA;
    assign mix_on    = ~ctrl_q.mixer_bypass_select & ~ctrl_q.comb_bypass_select;
    assign cfg_ok    = ctrl_q.burst_path_select
                     | ratio_ok(J_RATIO, ctrl_q.comb_bypass_select, ctrl_q.mixer_bypass_select);
    // Source cannot stall, so samples arriving without room are dropped here
    assign accept    = src_valid & fifo_in_room & cfg_ok;
    assign cfg       = cfg_for(J_RATIO);

    always_ff @(posedge CLK_SYS or negedge rst_n) begin
        if (!rst_n) begin
            mix_q   <= '0;
            mix_v_q <= 1'b0;
        end else begin
            mix_v_q <= accept;
            if (accept && mix_on) begin
                mix_q.i <= mul_q15(src_data, OSC_COS);
                mix_q.q <= 16'(-mul_q15(src_data, OSC_SIN));
            end else if (accept) begin
                mix_q.i <= src_data;
                mix_q.q <= 16'sh0000;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Decimators sit behind the mixer so they see the tuned signal
    always_comb begin
        stg_in[0] = mix_q;
        stg_v[0]  = mix_v_q & ~ctrl_q.burst_path_select;
        for (int k = 1; k < 4; k++) begin
            stg_in[k] = slot_out_q[k-1];
            stg_v[k]  = slot_v_q[k-1];
        end
    end

    // A ratio change mid-stream leaves partial sums; reprogram while idle
    always_ff @(posedge CLK_SYS or negedge rst_n) begin
        if (!rst_n) begin
            for (int k = 0; k < 4; k++) begin
                slot_out_q[k] <= '0;
                slot_v_q[k]   <= 1'b0;
                acc_i_q[k]    <= '0;
                acc_q_q[k]    <= '0;
                slot_cnt_q[k] <= '0;
            end
        end else begin
            for (int k = 0; k < 4; k++) begin
                slot_v_q[k] <= 1'b0;
                if (stg_v[k] && !cfg[k].en) begin
                    slot_out_q[k] <= stg_in[k];
                    slot_v_q[k]   <= 1'b1;
                end else if (stg_v[k] && slot_cnt_q[k] == 3'(cfg[k].factor - 3'h1)) begin
                    slot_out_q[k].i <= stage_avg(acc_i_q[k] + 20'(stg_in[k].i), cfg[k].factor);
                    slot_out_q[k].q <= stage_avg(acc_q_q[k] + 20'(stg_in[k].q), cfg[k].factor);
                    slot_v_q[k]     <= 1'b1;
                    acc_i_q[k]      <= '0;
                    acc_q_q[k]      <= '0;
                    slot_cnt_q[k]   <= '0;
                end else if (stg_v[k]) begin
                    acc_i_q[k]    <= acc_i_q[k] + 20'(stg_in[k].i);
                    acc_q_q[k]    <= acc_q_q[k] + 20'(stg_in[k].q);
                    slot_cnt_q[k] <= slot_cnt_q[k] + 3'h1;
                end
            end
        end
    end

    assign fifo_wv = ctrl_q.burst_path_select ? mix_v_q : slot_v_q[3];
    assign fifo_wd = ctrl_q.burst_path_select ? mix_q : slot_out_q[3];

    sample_fifo #(
        .WIDTH   (2 * `SAMPLE_W),
        .DEPTH   (`FIFO_DEPTH),
        .RESERVE (`FIFO_RESERVE)
    ) u_fifo (
        .clk       (CLK_SYS),
        .rst_n     (rst_n),
        .in_valid  (fifo_wv),
        .in_ready  (fifo_in_ready),
        .in_room   (fifo_in_room),
        .in_data   (fifo_wd),
        .out_valid (OUT_VALID),
        .out_ready (OUT_READY),
        .out_data  (OUT_DATA)
    );

    ////////////////////////////////////////////////////////////////////////////
    property p_src_select;
        @(posedge CLK_SYS) disable iff (!rst_n)
        accept && ctrl_q.comb_bypass_select |-> src_data == ADC_DATA && ADC_VALID;
    endproperty
    a_src_select: assert property (p_src_select) else $error("raw source not selected");

    property p_mixer_bypass;
        @(posedge CLK_SYS) disable iff (!rst_n)
        accept && ctrl_q.mixer_bypass_select |=> mix_v_q && mix_q.i == $past(src_data) && mix_q.q == 16'sh0000;
    endproperty
    a_mixer_bypass: assert property (p_mixer_bypass) else $error("mixer not bypassed");

    property p_raw_no_mix;
        @(posedge CLK_SYS) disable iff (!rst_n)
        ctrl_q.comb_bypass_select |-> !mix_on;
    endproperty
    a_raw_no_mix: assert property (p_raw_no_mix) else $error("mixer active on raw path");

    property p_burst_bypass;
        @(posedge CLK_SYS) disable iff (!rst_n)
        ctrl_q.burst_path_select |-> fifo_wv == mix_v_q && !stg_v[0];
    endproperty
    a_burst_bypass: assert property (p_burst_bypass) else $error("J block not bypassed");

    property p_invalid_ratio;
        @(posedge CLK_SYS) disable iff (!rst_n)
        !cfg_ok |-> !accept ##1 RATIO_ERR && !mix_v_q;
    endproperty
    a_invalid_ratio: assert property (p_invalid_ratio) else $error("invalid ratio let sample through");

    property p_pass_ratio1;
        @(posedge CLK_SYS) disable iff (!rst_n)
        mix_v_q && J_RATIO == 6'h01 && !ctrl_q.burst_path_select && $stable(J_RATIO) |-> ##4 slot_v_q[3];
    endproperty
    a_pass_ratio1: assert property (p_pass_ratio1) else $error("ratio 1 not pass-through");

    property p_cfg_half;
        @(posedge CLK_SYS) disable iff (!rst_n)
        J_RATIO == 6'h10 |-> cfg[0].factor == 3'h2 && cfg[3].en && cfg[2].factor == 3'h2;
    endproperty
    a_cfg_half: assert property (p_cfg_half) else $error("ratio 16 stages wrong");

    property p_cfg_fifth;
        @(posedge CLK_SYS) disable iff (!rst_n)
        J_RATIO == 6'h28 |-> cfg[1].factor == 3'h5 && cfg[2].factor == 3'h2 && cfg[3].en;
    endproperty
    a_cfg_fifth: assert property (p_cfg_fifth) else $error("ratio 40 stages wrong");

    property p_cfg_third;
        @(posedge CLK_SYS) disable iff (!rst_n)
        J_RATIO == 6'h1E |-> cfg[1].factor == 3'h5 && cfg[2].factor == 3'h3 && !cfg[3].en;
    endproperty
    a_cfg_third: assert property (p_cfg_third) else $error("ratio 30 stages wrong");

    c_ratio60: cover property (@(posedge CLK_SYS) disable iff (!rst_n) J_RATIO == 6'h3C && slot_v_q[3]);
    c_burst:   cover property (@(posedge CLK_SYS) disable iff (!rst_n) ctrl_q.burst_path_select && fifo_wv);
    c_mixed:   cover property (@(posedge CLK_SYS) disable iff (!rst_n) mix_on && OUT_VALID && OUT_READY);
    c_full:    cover property (@(posedge CLK_SYS) disable iff (!rst_n) !fifo_in_ready);
endmodule

// >>> verif/nbdj_partner.sv
`timescale 1ns/1ps
module nbdj_partner (
    input  wire logic          clk,
    input  wire logic [1:0]    mode,
    output logic               comb_valid,
    output logic [15:0]        comb_data,
    output logic               adc_valid,
    output logic [15:0]        adc_data,
    input  wire logic          out_valid,
    input  wire nbdj_pkg::iq_t out_data,
    output logic               out_ready
);
    import nbdj_pkg::*;
    iq_t  rx_q[$];
    logic tick;

    initial begin
        comb_valid = 1'b0;
        comb_data  = 16'h0000;
        adc_valid  = 1'b0;
        adc_data   = 16'h0000;
        out_ready  = 1'b1;
        tick       = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////
    // Idle lines flip their data on every idle cycle, so a stale sample never looks valid
    task automatic idle();
        comb_valid = 1'b0;
        adc_valid  = 1'b0;
        comb_data  = ~comb_data;
        adc_data   = ~adc_data;
    endtask

    // One 16-bit word per strobe, strobes spaced by the upstream ratio
    task automatic send(input int n, input int gap, input logic [15:0] base, input logic step, input logic raw);
        logic [15:0] d;
        d = base;
        for (int k = 0; k < n; k++) begin
            @(negedge clk);
            adc_valid  = raw;
            comb_valid = !raw;
            adc_data   = raw ? d : ~adc_data;
            comb_data  = raw ? ~comb_data : d;
            d          = d + {15'h0000, step};
            repeat (gap - 1) begin
                @(negedge clk);
                idle();
            end
        end
        @(negedge clk);
        idle();
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Mode 0 always ready, 1 stalls every other cycle, 2 stalls fully
    always @(negedge clk) begin
        tick      <= !tick;
        out_ready <= (mode == 2'd0) || (mode == 2'd1 && tick);
    end

    always @(posedge clk) begin
        if (out_valid && out_ready) begin
            rx_q.push_back(out_data);
        end
    end
endmodule

// >>> verif/tb.sv
`timescale 1ns/1ps
module tb;
    import nbdj_pkg::*;
    logic        clk_sys;
    logic        rstn;
    logic        cfg_we;
    logic [14:0] cfg_addr;
    logic [7:0]  cfg_wdata;
    logic [7:0]  cfg_rdata;
    logic        adc_valid;
    logic [15:0] adc_data;
    logic        comb_valid;
    logic [15:0] comb_data;
    logic [15:0] osc_cos;
    logic [15:0] osc_sin;
    logic [5:0]  j_ratio;
    logic        sample_ready;
    logic        ratio_err;
    logic        out_valid;
    logic        out_ready;
    iq_t         out_data;
    logic [1:0]  mode;
    int          n_mismatch;
    int          n_checks;
    int          n_exp;
    int          ratios[11] = '{1, 4, 8, 10, 12, 16, 20, 24, 30, 40, 60};

    nonburst_decimate_j_chain u_nonburst_decimate_j_chain (
        .CLK_SYS(clk_sys), .RSTN(rstn), .CFG_WE(cfg_we), .CFG_ADDR(cfg_addr), .CFG_WDATA(cfg_wdata),
        .CFG_RDATA(cfg_rdata), .ADC_VALID(adc_valid), .ADC_DATA(adc_data), .COMB_VALID(comb_valid),
        .COMB_DATA(comb_data), .OSC_COS(osc_cos), .OSC_SIN(osc_sin), .J_RATIO(j_ratio),
        .SAMPLE_READY(sample_ready), .RATIO_ERR(ratio_err), .OUT_VALID(out_valid), .OUT_READY(out_ready),
        .OUT_DATA(out_data));

    nbdj_partner u_nbdj_partner (
        .clk(clk_sys), .mode(mode), .comb_valid(comb_valid), .comb_data(comb_data), .adc_valid(adc_valid),
        .adc_data(adc_data), .out_valid(out_valid), .out_data(out_data), .out_ready(out_ready));

    ////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic end_of_test();
        $display("checks=%0d mismatches=%0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // Fresh reset per scenario: a ratio change leaves partial sums behind
    task automatic setup(input logic [7:0] ctrl, input logic [5:0] r, input logic [15:0] c, input logic [15:0] s);
        @(negedge clk_sys);
        rstn    = 1'b0;
        mode    = 2'd0;
        j_ratio = r;
        osc_cos = c;
        osc_sin = s;
        repeat (5) @(negedge clk_sys);
        rstn = 1'b1;
        repeat (3) @(negedge clk_sys);
        u_nbdj_partner.rx_q.delete();
        cfg_write(15'h0116, ctrl);
    endtask

    task automatic cfg_write(input logic [14:0] a, input logic [7:0] d);
        @(negedge clk_sys);
        cfg_we    = 1'b1;
        cfg_addr  = a;
        cfg_wdata = d;
        @(negedge clk_sys);
        cfg_we = 1'b0;
    endtask

    task automatic cfg_read(input logic [14:0] a, output logic [7:0] d);
        @(negedge clk_sys);
        cfg_addr = a;
        repeat (2) @(negedge clk_sys);
        d = cfg_rdata;
    endtask

    // Catches the error flag whether it is a pulse or a level
    task automatic err_window(output logic seen);
        seen = 1'b0;
        repeat (3) begin
            @(negedge clk_sys);
            seen = seen | ratio_err;
        end
    endtask

    task automatic wait_cnt(input int n);
        repeat (n) @(negedge clk_sys);
        check(32'(u_nbdj_partner.rx_q.size()), 32'(n_exp));
    endtask

    ////////////////////////////////////////////////////////////////////////
    task automatic t_regs();
        logic [7:0] rd;
        setup(8'h00, 6'd1, 16'h4000, 16'h0000);
        cfg_read(15'h0116, rd);
        check({24'h000000, rd}, 32'h00000000);
        cfg_write(15'h0116, 8'hF6);
        cfg_write(15'h0117, 8'h55);
        cfg_read(15'h0116, rd);
        check({24'h000000, rd}, 32'h000000F6);
        cfg_read(15'h0117, rd);
        check({24'h000000, rd}, 32'h00000000);
    endtask

    task automatic t_table();
        logic [7:0]  route[3] = '{8'h12, 8'h02, 8'h00};
        logic [10:0] ok[3]    = '{11'h6F4, 11'h7FF, 11'h027};
        logic        seen;
        setup(8'h12, 6'd4, 16'h4000, 16'h0000);
        u_nbdj_partner.send(20, 1, 16'h0100, 1'b0, 1'b1);
        n_exp = 0;
        wait_cnt(10);
        for (int r = 0; r < 3; r++) begin
            cfg_write(15'h0116, route[r]);
            for (int k = 0; k < 11; k++) begin
                @(negedge clk_sys);
                j_ratio = 6'(ratios[k]);
                u_nbdj_partner.send(1, 1, 16'h0100, 1'b0, route[r][4]);
                err_window(seen);
                check({31'h0, seen}, {31'h0, !ok[r][k]});
            end
        end
    endtask

    task automatic t_decim();
        for (int k = 0; k < 11; k++) begin
            setup(8'h02, 6'(ratios[k]), 16'h4000, 16'h2000);
            u_nbdj_partner.send(2 * ratios[k], 4, 16'h0F00, 1'b0, 1'b0);
            n_exp = 2;
            wait_cnt(30);
            while (u_nbdj_partner.rx_q.size() > 0) begin
                check(u_nbdj_partner.rx_q.pop_front(), 32'h00000F00);
            end
        end
    endtask

    task automatic t_raw();
        setup(8'h10, 6'd8, 16'h4000, 16'h2000);
        u_nbdj_partner.send(8, 1, 16'h0F00, 1'b0, 1'b0);
        u_nbdj_partner.send(8, 1, 16'h0F00, 1'b0, 1'b1);
        n_exp = 1;
        wait_cnt(30);
        check(u_nbdj_partner.rx_q.pop_front(), 32'h00000F00);
    endtask

    task automatic t_mixer();
        setup(8'h00, 6'd1, 16'h4000, 16'h2000);
        u_nbdj_partner.send(1, 4, 16'h1000, 1'b0, 1'b0);
        n_exp = 1;
        wait_cnt(10);
        check(u_nbdj_partner.rx_q.pop_front(), 32'hFC000800);
    endtask

    task automatic t_burst();
        logic seen;
        setup(8'h04, 6'd30, 16'h4000, 16'h0000);
        u_nbdj_partner.send(3, 4, 16'h1000, 1'b0, 1'b0);
        err_window(seen);
        check({31'h0, seen}, 32'h0);
        n_exp = 3;
        wait_cnt(10);
        cfg_write(15'h0116, 8'h14);
        u_nbdj_partner.send(1, 1, 16'h0F00, 1'b0, 1'b1);
        err_window(seen);
        check({31'h0, seen}, 32'h0);
        n_exp = 4;
        wait_cnt(10);
        repeat (3) check(u_nbdj_partner.rx_q.pop_front(), 32'h00000800);
        check(u_nbdj_partner.rx_q.pop_front(), 32'h00000F00);
    endtask

    task automatic t_fifo();
        int n;
        setup(8'h02, 6'd1, 16'h4000, 16'h0000);
        mode = 2'd2;
        u_nbdj_partner.send(40, 1, 16'h0200, 1'b1, 1'b0);
        repeat (10) @(negedge clk_sys);
        check({31'h0, sample_ready}, 32'h0);
        mode = 2'd1;
        repeat (100) @(negedge clk_sys);
        check({31'h0, sample_ready}, 32'h1);
        n = u_nbdj_partner.rx_q.size();
        check({31'h0, n >= 24 && n <= 32}, 32'h1);
        for (int k = 0; k < n; k++) begin
            check(u_nbdj_partner.rx_q[k], {16'h0000, 16'h0200 + 16'(k)});
        end
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial begin
        clk_sys = 1'b0;
        forever #2 clk_sys = ~clk_sys;
    end

    initial begin
        rstn      = 1'b0;
        cfg_we    = 1'b0;
        cfg_addr  = 15'h0000;
        cfg_wdata = 8'h00;
        osc_cos   = 16'h0000;
        osc_sin   = 16'h0000;
        j_ratio   = 6'd1;
        mode      = 2'd0;
        t_regs();
        t_table();
        t_decim();
        t_raw();
        t_mixer();
        t_burst();
        t_fifo();
        end_of_test();
    end

    // Whole run takes well under 8000 cycles
    initial begin
        repeat (20000) @(posedge clk_sys);
        n_mismatch++;
        end_of_test();
    end
endmodule
